// *** rtl/ftfap_pkg.sv ***
// Package for the frame type filter and automatic pending block.
// Assumes a Wishbone word bus where register index n sits at byte address 4*n.
package ftfap_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [5:0] FTFAP_IDX_MAIN = 6'h00;
	localparam logic [5:0] FTFAP_IDX_TYPE = 6'h01;
	localparam logic [5:0] FTFAP_IDX_SRCM = 6'h02;
	localparam logic [5:0] FTFAP_IDX_SEN0 = 6'h04;
	localparam logic [5:0] FTFAP_IDX_SEN1 = 6'h05;
	localparam logic [5:0] FTFAP_IDX_SEN2 = 6'h06;
	localparam logic [5:0] FTFAP_IDX_PND0 = 6'h08;
	localparam logic [5:0] FTFAP_IDX_PND1 = 6'h09;
	localparam logic [5:0] FTFAP_IDX_PND2 = 6'h0a;
	localparam logic [5:0] FTFAP_IDX_STAT = 6'h0c;
	localparam logic [5:0] FTFAP_IDX_TBL = 6'h10;

	// Reset values.
	localparam logic [7:0] FTFAP_RST_MAIN = 8'h0d;
	localparam logic [7:0] FTFAP_RST_TYPE = 8'h78;
	localparam logic [7:0] FTFAP_RST_SRCM = 8'h07;

	// Field positions in the main filter configuration register.
	localparam int FTFAP_B_FILT_EN = 0;

	// Field positions in the frame type accept configuration register.
	localparam int FTFAP_B_RSV_ACC = 7;
	localparam int FTFAP_B_CMD_ACC = 6;
	localparam int FTFAP_B_ACK_ACC = 5;
	localparam int FTFAP_B_DAT_ACC = 4;
	localparam int FTFAP_B_BCN_ACC = 3;
	localparam int FTFAP_B_MOD_HI = 2;
	localparam int FTFAP_B_MOD_LO = 1;

	// Field positions in the source match control register.
	localparam int FTFAP_B_REQ_ONLY = 2;
	localparam int FTFAP_B_AUTO_PENDING_FLAG_ENABLE = 1;
	localparam int FTFAP_B_SRC_EN = 0;

	// Frame type codes and the data request command identifier.
	localparam logic [2:0] FTFAP_FT_BEACON = 3'h0;
	localparam logic [2:0] FTFAP_FT_DATA = 3'h1;
	localparam logic [2:0] FTFAP_FT_ACK = 3'h2;
	localparam logic [2:0] FTFAP_FT_CMD = 3'h3;
	localparam logic [7:0] FTFAP_CMD_DATA_REQ = 8'h04;

	// Type modify encodings.
	typedef enum logic [1:0] {
		FTFAP_MOD_KEEP = 2'h0,
		FTFAP_MOD_INV = 2'h1,
		FTFAP_MOD_CLR = 2'h2,
		FTFAP_MOD_SET = 2'h3
	} ftfap_mod_e;

	// Header fields of one received frame, offered by the receive datapath.
	typedef struct packed {
		logic [2:0] frame_type;
		logic [7:0] cmd_id;
		logic src_short;
		logic [15:0] src_addr;
	} ftfap_frame_s;

	// Decision returned for one frame.
	typedef struct packed {
		logic valid;
		logic accept;
		logic pending;
		logic hit;
		logic [4:0] hit_index;
		logic [2:0] stored_type;
	} ftfap_result_s;

endpackage

// *** rtl/ftfap_top.sv ***
// Frame type filter and automatic pending flag decision with Wishbone registers.
// Assumes header fields arrive synchronous to clk_i with a one-cycle valid pulse.
//
// Behaviour
// RL1: Reserved types 100 to 111 pass only when the reserved accept bit is set.
// RL2: Command frames, type 011, pass only when the command accept bit is set.
// RL3: Acknowledgment frames, type 010, pass only when their accept bit is set.
// RL4: Data frames, type 001, pass only when the data accept bit is set.
// RL5: Beacon frames, type 000, pass only when the beacon accept bit is set.
// RL6: The modify field keeps, inverts, clears or sets the type MSB before filtering.
// RL7: Only the filter sees the modified type; stored frame keeps the original type.
// RL8: With request-only set, pending also needs a data request command frame.
// RL9: Pending needs filter, matching, auto_pending_flag_enable, request condition and a masked hit.
// RL10: The source match enable is ignored while frame filtering is off.
// RL11: A 24-bit enable word lets each short table entry take part in matching.
// RL12: Enable bits 7:0 and 15:8 live in the first and second enable registers.
// RL13: Software may clear an entry's enable bit before rewriting that entry.
// RL14: Software writes zero to reserved bits of type and match control registers.
// RL15: With filtering off, every frame is accepted and accept settings are ignored.
// RL16: Enable bits 23:16 live in a third enable register after the other two.
// RL17: The match result is formed in the cycle after the header fields arrive.
//
// Register access over Wishbone is this design's own decision.

`timescale 1ns/10ps
`default_nettype none

module ftfap_top
	import ftfap_pkg::*;
#(
	parameter int ENTRIES = 24
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic frame_valid_i,
	input wire ftfap_frame_s frame_i,
	output ftfap_result_s result_o
);

	// Applies the type modify field to the MSB only.
	function automatic logic [2:0] ftfap_modify(input logic [2:0] ft, input logic [1:0] mode);
		logic [2:0] res;
		res = ft;
		unique case (ftfap_mod_e'(mode))
			FTFAP_MOD_KEEP: res = ft;
			FTFAP_MOD_INV: res[2] = ~ft[2];
			FTFAP_MOD_CLR: res[2] = 1'b0;
			FTFAP_MOD_SET: res[2] = 1'b1;
		endcase
		return res; // see RL6
	endfunction

	// Looks up the accept bit for a frame type.
	function automatic logic ftfap_type_ok(input logic [2:0] ft, input logic [7:0] cfg);
		logic ok;
		ok = 1'b0;
		if (ft[2])
			ok = cfg[FTFAP_B_RSV_ACC]; // see RL1
		else if (ft == FTFAP_FT_CMD)
			ok = cfg[FTFAP_B_CMD_ACC]; // see RL2
		else if (ft == FTFAP_FT_ACK)
			ok = cfg[FTFAP_B_ACK_ACC]; // see RL3
		else if (ft == FTFAP_FT_DATA)
			ok = cfg[FTFAP_B_DAT_ACC]; // see RL4
		else
			ok = cfg[FTFAP_B_BCN_ACC]; // see RL5
		return ok;
	endfunction

	// Configuration state.
	logic [7:0] main_r;
	logic [7:0] main_nxt;
	logic [7:0] type_r;
	logic [7:0] type_nxt;
	logic [7:0] srcm_r;
	logic [7:0] srcm_nxt;
	logic [ENTRIES-1:0] sen_r;
	logic [ENTRIES-1:0] sen_nxt;
	logic [ENTRIES-1:0] pnd_r;
	logic [ENTRIES-1:0] pnd_nxt;
	logic [15:0] tbl_r [ENTRIES];
	logic [15:0] tbl_nxt [ENTRIES];

	// Bus state.
	logic ack_r;
	logic ack_nxt;
	logic [31:0] rdat_r;
	logic [31:0] rdat_nxt;

	// Decision state.
	ftfap_result_s res_r;
	ftfap_result_s res_nxt;

	// Decode helpers.
	logic [5:0] idx;
	logic wr_en;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic [ENTRIES-1:0] hit_vec;
	logic [ENTRIES-1:0] pend_vec;
	logic [4:0] first_hit;

	assign idx = wb_adr_i[7:2];
	assign wbyte = wb_dat_i[7:0];
	// A write lands once, in the cycle the answer is formed, and only on lane 0.
	assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r & wb_sel_i[0];

	// Per-entry comparators, all working in parallel so the hit is ready in one cycle.
	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++)
		begin : g_cmp
			assign hit_vec[gi] = sen_r[gi] & frame_i.src_short
				& (tbl_r[gi] == frame_i.src_addr); // see RL11, RL17
			assign pend_vec[gi] = hit_vec[gi] & pnd_r[gi]; // see RL9
		end
	endgenerate

	// Lowest matching entry number, reported for software visibility.
	always_comb
	begin
		first_hit = 5'h00;
		for (int i = ENTRIES - 1; i >= 0; i--)
		begin
			if (hit_vec[i])
				first_hit = 5'(i);
		end
	end

	// Register writes; reserved bits are stored as written since software keeps them zero.
	always_comb
	begin
		main_nxt = main_r;
		type_nxt = type_r;
		srcm_nxt = srcm_r;
		sen_nxt = sen_r;
		pnd_nxt = pnd_r;
		tbl_nxt = tbl_r;
		if (wr_en)
		begin
			unique case (idx)
				FTFAP_IDX_MAIN: main_nxt = wbyte;
				FTFAP_IDX_TYPE: type_nxt = wbyte; // see RL14
				FTFAP_IDX_SRCM: srcm_nxt = wbyte; // see RL14
				FTFAP_IDX_SEN0: sen_nxt[7:0] = wbyte; // see RL12
				FTFAP_IDX_SEN1: sen_nxt[15:8] = wbyte; // see RL12
				FTFAP_IDX_SEN2: sen_nxt[23:16] = wbyte; // see RL16
				FTFAP_IDX_PND0: pnd_nxt[7:0] = wbyte;
				FTFAP_IDX_PND1: pnd_nxt[15:8] = wbyte;
				FTFAP_IDX_PND2: pnd_nxt[23:16] = wbyte;
				default:
				begin
					// Table bytes: entry n low byte at base+2n, high byte at base+2n+1.
					for (int i = 0; i < ENTRIES; i++)
					begin
						if (idx == FTFAP_IDX_TBL + 6'(2 * i))
							tbl_nxt[i][7:0] = wbyte;
						if (idx == FTFAP_IDX_TBL + 6'(2 * i + 1))
							tbl_nxt[i][15:8] = wbyte;
					end
				end
			endcase
		end
	end

	// Configuration registers.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			main_r <= FTFAP_RST_MAIN;
			type_r <= FTFAP_RST_TYPE;
			srcm_r <= FTFAP_RST_SRCM;
			sen_r <= '0;
			pnd_r <= '0;
			for (int i = 0; i < ENTRIES; i++)
				tbl_r[i] <= 16'h0000;
		end
		else if (ce_i)
		begin
			main_r <= main_nxt;
			type_r <= type_nxt;
			srcm_r <= srcm_nxt;
			sen_r <= sen_nxt;
			pnd_r <= pnd_nxt;
			tbl_r <= tbl_nxt;
		end
	end

	// Read mux; unmapped indices read as zero and still answer.
	always_comb
	begin
		rbyte = 8'h00;
		unique case (idx)
			FTFAP_IDX_MAIN: rbyte = main_r;
			FTFAP_IDX_TYPE: rbyte = type_r;
			FTFAP_IDX_SRCM: rbyte = srcm_r;
			FTFAP_IDX_SEN0: rbyte = sen_r[7:0];
			FTFAP_IDX_SEN1: rbyte = sen_r[15:8];
			FTFAP_IDX_SEN2: rbyte = sen_r[23:16];
			FTFAP_IDX_PND0: rbyte = pnd_r[7:0];
			FTFAP_IDX_PND1: rbyte = pnd_r[15:8];
			FTFAP_IDX_PND2: rbyte = pnd_r[23:16];
			FTFAP_IDX_STAT: rbyte = {res_r.accept, res_r.pending, res_r.hit, res_r.hit_index};
			default:
			begin
				for (int i = 0; i < ENTRIES; i++)
				begin
					if (idx == FTFAP_IDX_TBL + 6'(2 * i))
						rbyte = tbl_r[i][7:0];
					if (idx == FTFAP_IDX_TBL + 6'(2 * i + 1))
						rbyte = tbl_r[i][15:8];
				end
			end
		endcase
	end

	// Answer one cycle after the request; ack drops in the following cycle.
	always_comb
	begin
		ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
		rdat_nxt = rdat_r;
		if (ack_nxt)
			rdat_nxt = {24'h000000, rbyte};
	end

	// Bus answer registers.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			rdat_r <= 32'h00000000;
		end
		else if (ce_i)
		begin
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	// Frame decision. The filter looks at a modified copy of the type; the type handed
	// on for storage is the received one, so software never sees the rewrite.
	always_comb
	begin
		logic filt_on;
		logic [2:0] ft_mod;
		logic req_ok;
		filt_on = main_r[FTFAP_B_FILT_EN];
		ft_mod = ftfap_modify(frame_i.frame_type, type_r[FTFAP_B_MOD_HI:FTFAP_B_MOD_LO]);
		// The command check uses the received type, not the filter's modified copy.
		req_ok = ~srcm_r[FTFAP_B_REQ_ONLY]
			| ((frame_i.frame_type == FTFAP_FT_CMD)
			& (frame_i.cmd_id == FTFAP_CMD_DATA_REQ)); // see RL8
		res_nxt = res_r;
		res_nxt.valid = 1'b0;
		if (frame_valid_i)
		begin
			res_nxt.valid = 1'b1;
			res_nxt.accept = ~filt_on | ftfap_type_ok(ft_mod, type_r); // see RL15
			// Filter off forces hit and pending low, whatever the enable holds; hit_index still follows the comparators.
			res_nxt.hit = filt_on & srcm_r[FTFAP_B_SRC_EN] & (|hit_vec); // see RL10
			res_nxt.hit_index = first_hit;
			res_nxt.pending = filt_on & srcm_r[FTFAP_B_SRC_EN]
				& srcm_r[FTFAP_B_AUTO_PENDING_FLAG_ENABLE] & req_ok & (|pend_vec); // see RL9
			res_nxt.stored_type = frame_i.frame_type; // see RL7
		end
	end

	// Decision register; the last result stays readable in the status register.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			res_r <= '0;
		else if (ce_i)
			res_r <= res_nxt;
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign result_o = res_r;

endmodule

`default_nettype wire

// *** dv/ftfap_chk.sv ***
// Port checker for the frame filter block, bound to its top.
// Assumes ce_i is high in normal running; the checks pause while it is low.
`timescale 1ns/10ps
`default_nettype none
module ftfap_chk
	import ftfap_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic frame_valid_i,
	input wire ftfap_frame_s frame_i,
	input wire ftfap_result_s result_o
);
	// All checks share the one clock and its reset.
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);
	a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) // Bus handshake.
		else $error("request not acknowledged");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) // Bus handshake.
		else $error("ack longer than one cycle");
	a_valid_next: assert property (frame_valid_i |=> result_o.valid)
		else $error("result late");
	a_valid_only: assert property (!frame_valid_i |=> !result_o.valid)
		else $error("result without frame");
	a_type_kept: assert property (frame_valid_i |=> result_o.stored_type == $past(frame_i.frame_type))
		else $error("stored type altered");
	a_pend_hit: assert property (result_o.valid && result_o.pending |-> result_o.hit)
		else $error("pending without hit");
	a_pend_short: assert property (frame_valid_i ##1 result_o.pending |-> $past(frame_i.src_short))
		else $error("pending on long source");
	a_fields_hold: assert property (!frame_valid_i |=> $stable(result_o.stored_type) && $stable(result_o.hit_index))
		else $error("result fields moved");
	// Main scenarios worth seeing at least once.
	c_pend: cover property (result_o.valid && result_o.pending);
	c_rej: cover property (result_o.valid && !result_o.accept);
	c_rd: cover property (wb_ack_o && !wb_we_i);
endmodule
bind ftfap_top ftfap_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.frame_valid_i(frame_valid_i), .frame_i(frame_i), .result_o(result_o));
`default_nettype wire

// *** dv/ftfap_rx_src.sv ***
// Stand-in for the receive datapath that offers frame headers.
// Assumes one header per call, driven just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module ftfap_rx_src
	import ftfap_pkg::*;
(
	input wire logic clk_i,
	output logic frame_valid_o,
	output ftfap_frame_s frame_o
);
	initial
	begin
		frame_valid_o = 1'b0;
		frame_o = '0;
	end
	// One-cycle pulse; fields are inverted afterwards so stale headers cannot pass for live ones.
	task automatic send(input ftfap_frame_s f);
		@(posedge clk_i);
		frame_valid_o <= 1'b1;
		frame_o <= f;
		@(posedge clk_i);
		frame_valid_o <= 1'b0;
		frame_o <= ~f;
	endtask
endmodule
`default_nettype wire

// *** dv/ftfap_top_test.sv ***
// Self-checking bench for the frame filter block.
// Assumes the checker binds itself from its own file.
`timescale 1ns/10ps
`default_nettype none
module ftfap_top_test;
	import ftfap_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] q;
	logic [31:0] rdat;
	logic ack;
	logic fv;
	ftfap_frame_s fr;
	ftfap_result_s res;
	logic [7:0] rm [64];
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h15;
	always #2 clk_i = ~clk_i;
	ftfap_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .frame_valid_i(fv), .frame_i(fr), .result_o(res));
	ftfap_rx_src RX (.clk_i(clk_i), .frame_valid_o(fv), .frame_o(fr));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Classic single cycle; the mirror follows writes except the unmapped slot.
	task automatic bus(input logic [5:0] i, input logic w, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= {24'h0, d};
		// Only the bench's cycle ceiling ends a wait that never sees ack.
		do
		begin
			@(posedge clk_i);
		end
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		we <= 1'b0;
		if (w && i != 6'h0e)
			rm[i] = d;
	endtask
	// Works out the decision from the mirror, then offers the frame.
	task automatic frame(input ftfap_frame_s f);
		logic [2:0] mt;
		logic on, acc, hit, pa, req;
		logic [4:0] ix;
		on = rm[0][0] && rm[2][0];
		req = !rm[2][2] || (f.frame_type == 3'h3 && f.cmd_id == 8'h04);
		mt = f.frame_type;
		case (rm[1][2:1]) 1: mt[2] = ~mt[2]; 2: mt[2] = 1'b0; 3: mt[2] = 1'b1; endcase
		acc = !rm[0][0] || rm[1][mt[2] ? 7 : 3 + mt[1:0]];
		hit = 1'b0;
		pa = 1'b0;
		ix = 5'h0;
		for (int n = 23; n >= 0; n--)
			if (rm[4 + n / 8][n % 8] && f.src_short && f.src_addr == {rm[17 + 2 * n], rm[16 + 2 * n]})
			begin
				hit = 1'b1;
				ix = 5'(n);
				pa |= rm[8 + n / 8][n % 8];
			end
		RX.send(f);
		#1;
		chk({res.valid, res.accept, res.pending, res.hit, res.stored_type}, {1'b1, acc, on && rm[2][1] && req && pa, on && hit, f.frame_type});
		if (on && hit)
			chk(res.hit_index, ix);
	endtask
	task automatic close_out();
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			error_cnt++;
			close_out();
		end
	end
	initial
	begin
		logic [31:0] r;
		ftfap_frame_s f;
		int n;
		foreach (rm[i]) rm[i] = 8'h00;
		rm[0] = 8'h0d;
		rm[1] = 8'h78;
		rm[2] = 8'h07;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		// A write to an unmapped slot that must not stick, then the reset values.
		bus(6'h0e, 1'b1, 8'hff);
		for (int i = 0; i < 16; i++)
		begin
			bus(6'(i), 1'b0, 8'h0);
			chk(q, {24'h0, rm[i]});
		end
		$display("test registers done");
		// Random table, enables and pending masks; the enable and pending words are read back.
		// Entries are filled while their enables are still clear, then enabled.
		for (int i = 16; i < 64; i++)
			bus(6'(i), 1'b1, 8'(rnd()));
		for (int i = 4; i < 11; i++)
			if (i != 7)
				bus(6'(i), 1'b1, 8'(rnd()));
		for (int i = 4; i < 11; i++)
		begin
			bus(6'(i), 1'b0, 8'h0);
			chk(q, {24'h0, rm[i]});
		end
		$display("test tables done");
		// Every type under every modify code with filtering on, then codes 2 and 3 with it off.
		for (int m = 0; m < 8; m++)
		begin
			bus(6'h00, 1'b1, {7'h06, 1'(m < 6)});
			bus(6'h01, 1'b1, {5'(rnd()), 2'(m), 1'b0});
			for (int t = 0; t < 8; t++)
				frame({3'(t), 8'(rnd()), 1'b1, 16'(rnd())});
		end
		$display("test types done");
		// Pending decision over all control settings, hits and misses mixed.
		for (int c = 0; c < 16; c++)
		begin
			bus(6'h02, 1'b1, {5'h0, 3'(c)});
			bus(6'h00, 1'b1, {7'h06, 1'(c < 12)});
			repeat (8)
			begin
				r = rnd();
				n = r[12:8] % 24;
				f.frame_type = r[0] ? 3'h3 : r[3:1];
				f.cmd_id = r[4] ? 8'h04 : r[31:24];
				f.src_short = r[5] | r[6];
				f.src_addr = r[7] ? {rm[17 + 2 * n], rm[16 + 2 * n]} : r[23:8];
				frame(f);
			end
		end
		$display("test pending done");
		close_out();
	end
endmodule
`default_nettype wire
